// ---- shared/csl_pkg.sv ----
// Purpose: constants and types for the configuration strap latch and decoder
// Assumes: straps are static board levels; one core clock at 10 MHz
// Notes: mode codes are five bits; unlisted codes fall to a neutral decode
`default_nettype none
package csl_pkg;
    // ==========================================================
    // strap vector layout
    localparam int STRAP_W = 8;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 5;
    localparam int ADDR_POS = 5;
    localparam int REFCLK_POS = 6;
    localparam int LED_POS = 7;
    // ==========================================================
    // device mode codes
    localparam logic [4:0] MODE_NAND_TREE = 5'h04;
    localparam logic [4:0] MODE_DEV_PDOWN = 5'h07;
    localparam logic [4:0] MODE_SW_PD_PLL_ON = 5'h08;
    localparam logic [4:0] MODE_SW_PD_PLL_OFF = 5'h09;
    localparam logic [4:0] MODE_F1000_HOST = 5'h0a;
    localparam logic [4:0] MODE_F100_FD = 5'h0b;
    localparam logic [4:0] MODE_F1000_CLIENT = 5'h0d;
    // ==========================================================
    // register layout of the plain port
    localparam logic [1:0] OFS_STRAP = 2'h0;
    localparam logic [1:0] OFS_CTRL = 2'h1;
    localparam logic [1:0] OFS_MODE = 2'h2;
    localparam int CTRL_BCAST_POS = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    // ==========================================================
    // decoded operating mode
    typedef enum logic [2:0] {
        OP_NORMAL, OP_NAND_TREE, OP_DEV_PDOWN, OP_SW_PD_PLL_ON,
        OP_SW_PD_PLL_OFF, OP_FORCED
    } csl_op_t;
    typedef enum logic [1:0] {SPD_NONE, SPD_100, SPD_1000} csl_speed_t;
endpackage
`default_nettype wire

// ---- rtl/csl_sync2.sv ----
// Purpose: two-flop synchroniser for a vector of strap pins
// Assumes: pins are asynchronous to core_clk
// Notes: first stage is read only by the second stage
`default_nettype none
module csl_sync2 #(
    parameter int W = 8
) (
    input wire logic core_clk,
    input wire logic rstSyncN,
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] pinSync
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } csl_sync_st_t;
    csl_sync_st_t st_r;
    csl_sync_st_t st_nxt;

    // ==========================================================
    // shift the pins through two stages
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.meta = pinIn;
        st_nxt.sync = st_r.meta;
    end

    always_ff @(posedge core_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign pinSync = st_r.sync;
endmodule
`default_nettype wire

// ---- rtl/config_strap_latch_decode.sv ----
// Purpose: latch configuration straps at reset release and decode settings
// Assumes: straps settle before reset release; core_clk 10 MHz
// Notes: registers on a plain port; broadcast bit writable after load
`default_nettype none
module config_strap_latch_decode
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [4:0] modeStrap,
    input wire logic shared_address_strap,
    input wire logic ref_clock_out_strap,
    input wire logic led_style_strap,
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    output logic broadcastAddrEn,
    output logic refClockOutEn,
    output logic ledIndividual,
    output logic [4:0] deviceMode,
    output var csl_pkg::csl_op_t opMode,
    output var csl_pkg::csl_speed_t forcedSpeed,
    output logic forcedFullDuplex,
    output logic clockHost,
    output logic autoNegEn,
    output logic autoMdixEn,
    output logic eeeEn,
    output logic adv1000Half,
    output logic strapsValid
);
    import csl_pkg::*;

    typedef struct packed {
        logic [1:0] rstPipe;
    } csl_rst_st_t;

    typedef struct packed {
        logic loaded;
        logic [STRAP_W-1:0] straps;
        logic bcast;
        logic [7:0] rdata;
        logic refClk;
        logic ledInd;
        logic [4:0] mode;
        csl_op_t op;
        csl_speed_t spd;
        logic fullDup;
        logic host;
        logic aneg;
        logic [1:0] fill;
    } csl_st_t;

    csl_rst_st_t rst_r;
    csl_rst_st_t rst_nxt;
    csl_st_t st_r;
    csl_st_t st_nxt;
    logic rstSyncN;
    logic [STRAP_W-1:0] strapPins;
    logic [STRAP_W-1:0] strapSync;
    logic syncFull;

    // ==========================================================
    // reset release through two flops
    always_comb
    begin
        rst_nxt.rstPipe = {rst_r.rstPipe[0], 1'b1};
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_r <= '0;
        end
        else
        begin
            rst_r <= rst_nxt;
        end
    end

    assign rstSyncN = rst_r.rstPipe[1];

    // ==========================================================
    // strap pins cross into the core domain
    assign strapPins = {led_style_strap, ref_clock_out_strap, shared_address_strap, modeStrap};

    csl_sync2 #(
        .W(STRAP_W)
    ) u_sync (
        .core_clk(core_clk),
        .rstSyncN(rstSyncN),
        .pinIn(strapPins),
        .pinSync(strapSync)
    );

    // decode a mode code into operating state
    function automatic csl_op_t decodeOp(input logic [4:0] m);
        csl_op_t o;
        o = OP_NORMAL;
        unique case (m)
            MODE_NAND_TREE: o = OP_NAND_TREE;
            MODE_DEV_PDOWN: o = OP_DEV_PDOWN;
            MODE_SW_PD_PLL_ON: o = OP_SW_PD_PLL_ON;
            MODE_SW_PD_PLL_OFF: o = OP_SW_PD_PLL_OFF;
            MODE_F1000_HOST, MODE_F100_FD, MODE_F1000_CLIENT: o = OP_FORCED;
            default: o = OP_NORMAL;
        endcase
        return o;
    endfunction

    // ==========================================================
    // capture, decode and register port
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rdata = RDATA_RESET;
        // count edges since release; saturates once the sync stages are full
        if (!st_r.fill[1])
        begin
            st_nxt.fill = st_r.fill + 2'h1;
        end
        if (!st_r.loaded)
        begin
            // the sync pipe needs two edges after release before its data are real
            st_nxt.loaded = 1'b1;
            st_nxt.straps = strapSync;
        end
        // hold off capture until the sync stages have refilled
        if (!st_r.loaded && !syncFull)
        begin
            st_nxt.loaded = 1'b0;
        end
        if (!st_r.loaded && syncFull)
        begin
            st_nxt.bcast = ~strapSync[ADDR_POS];
            st_nxt.refClk = strapSync[REFCLK_POS];
            st_nxt.ledInd = strapSync[LED_POS];
            st_nxt.mode = strapSync[MODE_LSB +: MODE_W];
            st_nxt.op = decodeOp(strapSync[MODE_LSB +: MODE_W]);
            st_nxt.spd = SPD_NONE;
            st_nxt.fullDup = 1'b0;
            st_nxt.host = 1'b0;
            st_nxt.aneg = (decodeOp(strapSync[MODE_LSB +: MODE_W]) == OP_NORMAL);
            if (strapSync[MODE_LSB +: MODE_W] == MODE_F1000_HOST)
            begin
                st_nxt.spd = SPD_1000;
                st_nxt.fullDup = 1'b1;
                st_nxt.host = 1'b1;
            end
            else if (strapSync[MODE_LSB +: MODE_W] == MODE_F100_FD)
            begin
                st_nxt.spd = SPD_100;
                st_nxt.fullDup = 1'b1;
            end
            else if (strapSync[MODE_LSB +: MODE_W] == MODE_F1000_CLIENT)
            begin
                st_nxt.spd = SPD_1000;
                st_nxt.fullDup = 1'b1;
            end
        end
        // software may rewrite the broadcast bit once loaded
        if (regWr && regAddr == OFS_CTRL && st_r.loaded)
        begin
            st_nxt.bcast = regWdata[CTRL_BCAST_POS];
        end
        if (regRd)
        begin
            unique case (regAddr)
                OFS_STRAP: st_nxt.rdata = st_r.straps;
                OFS_CTRL: st_nxt.rdata = {7'h00, st_r.bcast};
                OFS_MODE: st_nxt.rdata = {st_r.loaded, st_r.op, st_r.mode[3:0]};
                default: st_nxt.rdata = RDATA_RESET;
            endcase
        end
    end

    // two edges after release the sync stages hold real pin data
    assign syncFull = st_r.fill[1];

    always_ff @(posedge core_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // outputs straight from flops, except adv1000Half which is tied low
    assign regRdata = st_r.rdata;
    assign broadcastAddrEn = st_r.bcast;
    assign refClockOutEn = st_r.refClk;
    assign ledIndividual = st_r.ledInd;
    assign deviceMode = st_r.mode;
    assign opMode = st_r.op;
    assign forcedSpeed = st_r.spd;
    assign forcedFullDuplex = st_r.fullDup;
    assign clockHost = st_r.host;
    assign autoNegEn = st_r.aneg;
    assign autoMdixEn = st_r.aneg;
    assign eeeEn = st_r.aneg;
    assign adv1000Half = 1'b0;
    assign strapsValid = st_r.loaded;

    // ==========================================================
    // checks
    // frozen after load
    property p_frozen;
        @(posedge core_clk) disable iff (!rstSyncN)
        st_r.loaded |=> $stable(st_r.straps) && $stable(st_r.mode);
    endproperty
    a_frozen: assert property (p_frozen) else $error("straps changed after load");

    property p_inverse;
        @(posedge core_clk) disable iff (!rstSyncN)
        $rose(st_r.loaded) |-> broadcastAddrEn == ~st_r.straps[ADDR_POS];
    endproperty
    a_inverse: assert property (p_inverse) else $error("broadcast bit not inverse");

    property p_refclk;
        @(posedge core_clk) disable iff (!rstSyncN)
        st_r.loaded |-> refClockOutEn == st_r.straps[REFCLK_POS];
    endproperty
    a_refclk: assert property (p_refclk) else $error("ref clock enable mismatch");

    property p_led;
        @(posedge core_clk) disable iff (!rstSyncN)
        st_r.loaded |-> ledIndividual == st_r.straps[LED_POS];
    endproperty
    a_led: assert property (p_led) else $error("led style mismatch");

    property p_nand;
        @(posedge core_clk) disable iff (!rstSyncN)
        st_r.loaded && deviceMode == MODE_NAND_TREE |-> opMode == OP_NAND_TREE;
    endproperty
    a_nand: assert property (p_nand) else $error("nand tree decode wrong");

    property p_swpd;
        @(posedge core_clk) disable iff (!rstSyncN)
        st_r.loaded && deviceMode == MODE_SW_PD_PLL_OFF |-> opMode == OP_SW_PD_PLL_OFF;
    endproperty
    a_swpd: assert property (p_swpd) else $error("pll-off power-down decode wrong");

    property p_devpd;
        @(posedge core_clk) disable iff (!rstSyncN)
        st_r.loaded && deviceMode == MODE_DEV_PDOWN |-> opMode == OP_DEV_PDOWN;
    endproperty
    a_devpd: assert property (p_devpd) else $error("device power-down decode wrong");

    property p_pllon;
        @(posedge core_clk) disable iff (!rstSyncN)
        st_r.loaded && deviceMode == MODE_SW_PD_PLL_ON |-> opMode == OP_SW_PD_PLL_ON;
    endproperty
    a_pllon: assert property (p_pllon) else $error("pll-on power-down decode wrong");

    property p_f100;
        @(posedge core_clk) disable iff (!rstSyncN)
        st_r.loaded && deviceMode == MODE_F100_FD
        |-> forcedSpeed == SPD_100 && forcedFullDuplex && !clockHost && !autoNegEn;
    endproperty
    a_f100: assert property (p_f100) else $error("forced 100 decode wrong");

    property p_client;
        @(posedge core_clk) disable iff (!rstSyncN)
        st_r.loaded && deviceMode == MODE_F1000_CLIENT
        |-> forcedSpeed == SPD_1000 && forcedFullDuplex && !clockHost && !autoMdixEn && !eeeEn;
    endproperty
    a_client: assert property (p_client) else $error("forced client decode wrong");

    property p_host;
        @(posedge core_clk) disable iff (!rstSyncN)
        st_r.loaded && deviceMode == MODE_F1000_HOST
        |-> forcedSpeed == SPD_1000 && clockHost && !autoNegEn;
    endproperty
    a_host: assert property (p_host) else $error("forced host decode wrong");

    property p_load;
        @(posedge core_clk) disable iff (!rstSyncN)
        $rose(syncFull) |=> strapsValid && deviceMode == $past(strapSync[MODE_LSB +: MODE_W]);
    endproperty
    a_load: assert property (p_load) else $error("mode not captured at release");

    property p_nohalf;
        @(posedge core_clk) disable iff (!rstSyncN)
        strapsValid |-> !adv1000Half;
    endproperty
    a_nohalf: assert property (p_nohalf) else $error("gigabit half advertised");
endmodule
`default_nettype wire

// ---- dv/csl_strap_board.sv ----
// Purpose: board straps and reset driver facing the strap latch
// Assumes: straps are applied while reset is held low
// Notes: glitch inverts the pins every cycle after release
`default_nettype none
module csl_strap_board (
    input wire logic core_clk,
    input wire logic rstReq,
    input wire logic glitch,
    input wire logic [csl_pkg::STRAP_W-1:0] cfg,
    output logic resetn,
    output logic [4:0] modeStrap,
    output logic shared_address_strap,
    output logic ref_clock_out_strap,
    output logic led_style_strap
);
    timeunit 1ns;
    timeprecision 1ns;
    import csl_pkg::*;
    logic [STRAP_W-1:0] pins_r = 8'h10;
    logic rstn_r = 1'b0;
    // ==========================================================
    // pins settle during reset, release one edge later
    // straps settled before release
    always @(posedge core_clk)
    begin
        if (rstReq)
        begin
            if (cfg[4:0] inside {5'h02, 5'h03, 5'h05, 5'h06, 5'h0f, 5'h1e})
                pins_r <= {cfg[7:5], 5'h10};
            else
                pins_r <= cfg;
            rstn_r <= 1'b0;
        end
        else
        begin
            rstn_r <= 1'b1;
            // a late strap change, only when the bench asks for it
            if (glitch)
                pins_r <= ~pins_r;
        end
    end
    assign resetn = rstn_r;
    assign modeStrap = pins_r[MODE_LSB+:MODE_W];
    assign shared_address_strap = pins_r[ADDR_POS];
    assign ref_clock_out_strap = pins_r[REFCLK_POS];
    assign led_style_strap = pins_r[LED_POS];
endmodule
`default_nettype wire

// ---- dv/config_strap_latch_decode_tb.sv ----
// Purpose: self-checking bench for the strap latch and decoder
// Assumes: board model holds straps steady across each release
// Notes: every mode row is booted at least once, the first eight boots each with a different mix of the three upper strap bits
`default_nettype none
module config_strap_latch_decode_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import csl_pkg::*;
    logic core_clk = 1'b0;
    logic resetn, rstReq = 1'b1, glitch = 1'b0;
    logic [7:0] cfg = 8'h10, regWdata = 8'h00, regRdata;
    logic [4:0] modeStrap, deviceMode;
    logic shared_address_strap, ref_clock_out_strap, led_style_strap;
    logic [1:0] regAddr = 2'h0;
    logic regWr = 1'b0, regRd = 1'b0;
    logic broadcastAddrEn, refClockOutEn, ledIndividual, forcedFullDuplex, clockHost;
    logic autoNegEn, autoMdixEn, eeeEn, adv1000Half, strapsValid;
    csl_op_t opMode;
    csl_speed_t forcedSpeed;
    int bad_count = 0, cmp_count = 0;
    logic [4:0] codes [8] = '{5'h04, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0d, 5'h10};
    // ==========================================================
    // clock, board and device
    initial
    begin
        forever #50 core_clk = ~core_clk;
    end
    csl_strap_board u_board (.core_clk(core_clk), .rstReq(rstReq), .glitch(glitch),
        .cfg(cfg), .resetn(resetn), .modeStrap(modeStrap),
        .shared_address_strap(shared_address_strap),
        .ref_clock_out_strap(ref_clock_out_strap), .led_style_strap(led_style_strap));
    config_strap_latch_decode u_dut (.core_clk(core_clk), .resetn(resetn),
        .modeStrap(modeStrap), .shared_address_strap(shared_address_strap),
        .ref_clock_out_strap(ref_clock_out_strap), .led_style_strap(led_style_strap),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .broadcastAddrEn(broadcastAddrEn),
        .refClockOutEn(refClockOutEn), .ledIndividual(ledIndividual),
        .deviceMode(deviceMode), .opMode(opMode), .forcedSpeed(forcedSpeed),
        .forcedFullDuplex(forcedFullDuplex), .clockHost(clockHost), .autoNegEn(autoNegEn),
        .autoMdixEn(autoMdixEn), .eeeEn(eeeEn), .adv1000Half(adv1000Half),
        .strapsValid(strapsValid));
    // ==========================================================
    // report and compare helpers
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // ==========================================================
    // register port: one-cycle strobes, read data one cycle later only
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string nm);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        @(negedge core_clk);
        chk(nm, exp, regRdata);
        @(negedge core_clk);
        chk("idle read data", 8'h00, regRdata);
    endtask
    // reset with given straps, then wait for the latch to report loaded
    task automatic boot(input logic [7:0] c);
        int n;
        @(posedge core_clk);
        cfg <= c;
        rstReq <= 1'b1;
        repeat (5) @(posedge core_clk);
        rstReq <= 1'b0;
        @(negedge core_clk);
        chk("valid in reset", 8'h00, {7'h0, strapsValid});
        n = 0;
        while (strapsValid !== 1'b1 && n < 30)
        begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 30)
        begin
            bad_count++;
            final_report();
        end
    endtask
    // every decoded output against the strap vector
    task automatic verify(input logic [7:0] c);
        logic [2:0] op;
        logic [1:0] spd;
        logic frc;
        case (c[4:0])
            MODE_NAND_TREE: op = OP_NAND_TREE;
            MODE_DEV_PDOWN: op = OP_DEV_PDOWN;
            MODE_SW_PD_PLL_ON: op = OP_SW_PD_PLL_ON;
            MODE_SW_PD_PLL_OFF: op = OP_SW_PD_PLL_OFF;
            MODE_F1000_HOST, MODE_F100_FD, MODE_F1000_CLIENT: op = OP_FORCED;
            default: op = OP_NORMAL;
        endcase
        frc = (op == OP_FORCED);
        spd = (c[4:0] == MODE_F100_FD) ? SPD_100 : (frc ? SPD_1000 : SPD_NONE);
        chk("deviceMode", {3'h0, c[4:0]}, {3'h0, deviceMode});
        chk("opMode", {5'h0, op}, {5'h0, opMode});
        chk("bcast", {7'h0, ~c[ADDR_POS]}, {7'h0, broadcastAddrEn});
        chk("refclk", {7'h0, c[REFCLK_POS]}, {7'h0, refClockOutEn});
        chk("led", {7'h0, c[LED_POS]}, {7'h0, ledIndividual});
        chk("negotiate", {5'h0, {3{op == OP_NORMAL}}},
            {5'h0, autoNegEn, autoMdixEn, eeeEn});
        chk("adv1000Half", 8'h00, {7'h0, adv1000Half});
        chk("speed", {6'h0, spd}, {6'h0, forcedSpeed});
        // duplex and clock role must also stay low outside the forced rows
        chk("fd host", {6'h0, frc, c[4:0] == MODE_F1000_HOST},
            {6'h0, forcedFullDuplex, clockHost});
        rd(OFS_STRAP, c, "strap reg");
        rd(OFS_MODE, {1'b1, op, c[3:0]}, "mode reg");
    endtask
    // ==========================================================
    // main sequence
    initial
    begin
        for (int i = 0; i < 8; i++)
        begin
            boot({3'(i), codes[i]});
            verify({3'(i), codes[i]});
        end
        // pins toggle after the latch: an odd flip count leaves them inverted,
        // so a relatching design would show the inverted straps
        @(posedge core_clk);
        glitch <= 1'b1;
        repeat (9) @(posedge core_clk);
        glitch <= 1'b0;
        repeat (4) @(posedge core_clk);
        verify({3'h7, codes[7]});
        // software overrides the loaded broadcast default
        wr(OFS_CTRL, 8'h01);
        rd(OFS_CTRL, 8'h01, "ctrl set");
        chk("bcast written", 8'h01, {7'h0, broadcastAddrEn});
        wr(OFS_CTRL, 8'h00);
        rd(OFS_CTRL, 8'h00, "ctrl clear");
        wr(OFS_STRAP, 8'h00);
        rd(OFS_STRAP, {3'h7, codes[7]}, "strap reg kept");
        rd(2'h3, 8'h00, "unmapped");
        wr(OFS_CTRL, 8'h01);
        boot(8'h2b);
        verify(8'h2b);
        final_report();
    end
endmodule
`default_nettype wire
